// ===== host_link_pkg.sv
// constants and types shared by the host link status exchange block
`default_nettype none
package host_link_pkg;
	localparam int AW = 16;
	localparam int DW = 16;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL_BASE   = 8'h00;
	localparam logic [7:0] OFS_NOTIFY_BASE = 8'h04;
	localparam logic [7:0] OFS_DISP_ADDR   = 8'h08;
	localparam logic [7:0] OFS_ENABLE      = 8'h0c;
	localparam logic [7:0] OFS_STATUS      = 8'h10;
	localparam logic [7:0] OFS_DISP_VAL    = 8'h14;
	// word indices inside the control and notify areas
	localparam logic [1:0] CW_SCREEN    = 2'h0;
	localparam logic [1:0] CW_COPY_TBL  = 2'h1;
	localparam logic [1:0] CW_COPY_TYPE = 2'h2;
	localparam logic [1:0] CW_BITS      = 2'h3;
	localparam logic [1:0] NW_SCREEN    = 2'h0;
	localparam logic [1:0] NW_TABLE     = 2'h1;
	localparam logic [1:0] NW_STATUS    = 2'h2;
	localparam logic [15:0] COPY_STRING  = 16'h0000;
	localparam logic [15:0] COPY_NUMERAL = 16'h0001;
	localparam logic [15:0] SCREEN_NONE  = 16'h0000;
	// bit positions
	localparam int BIT_BACKLIGHT = 0;
	localparam int ST_RUN        = 0;
	localparam int ST_BACKLIGHT  = 1;
	localparam int ST_SCREEN_STB = 2;
	localparam int ST_NUM_STB    = 3;
	localparam int EN_RUN        = 0;
	// longest table allocations in host words
	localparam logic [3:0] NUM_MAX_WORDS = 4'h2;
	localparam logic [3:0] STR_MAX_WORDS = 4'ha;
	// reset values
	localparam logic [15:0] RST_BASE  = 16'h0000;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic        RST_DIRTY = 1'b1;
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_CTRL = 6'b000010,
		S_DISP = 6'b000100,
		S_EGET = 6'b001000,
		S_EWR  = 6'b010000,
		S_NOTE = 6'b100000
	} state_t;
endpackage
`default_nettype wire

// ===== link_port.sv
// single-word access engine towards the host memory link
`timescale 1ns/10ps
`default_nettype none
module link_port (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        start,
	input  wire logic        we,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             link_req,
	output logic             link_we,
	output logic [15:0]      link_addr,
	output logic [15:0]      link_wdata,
	input  wire logic        link_ack,
	input  wire logic [15:0] link_rdata
);
	// request holds steady until the link acknowledges it
	always_ff @(posedge CLK) begin
		if (SRST) begin
			link_req   <= 1'b0;
			link_we    <= 1'b0;
			link_addr  <= 16'h0000;
			link_wdata <= 16'h0000;
		end else if (start && !link_req) begin
			link_req   <= 1'b1;
			link_we    <= we;
			link_addr  <= addr;
			link_wdata <= wdata;
		end else if (link_req && link_ack) begin
			link_req <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			done  <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			done <= link_req && link_ack;
			if (link_req && link_ack && !link_we) begin
				rdata <= link_rdata;
			end
		end
	end
endmodule // link_port
`default_nettype wire

// ===== host_link_status_exchange.sv
// terminal side of the host status exchange: control poll, notify write, edits
`timescale 1ns/10ps
`default_nettype none
module host_link_status_exchange (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	input  wire logic [3:0]  SEL_I,
	output logic [31:0]      DAT_O,
	output logic             ACK_O,
	output logic             LINK_REQ,
	output logic             LINK_WE,
	output logic [15:0]      LINK_ADDR,
	output logic [15:0]      LINK_WDATA,
	input  wire logic        LINK_ACK,
	input  wire logic [15:0] LINK_RDATA,
	input  wire logic        EDIT_VALID,
	output logic             EDIT_READY,
	input  wire logic [15:0] EDIT_ADDR,
	input  wire logic [15:0] EDIT_DATA,
	input  wire logic        EDIT_LAST,
	input  wire logic        EDIT_NUMERAL,
	input  wire logic [15:0] EDIT_TABLE,
	output logic [15:0]      SCREEN,
	output logic             BACKLIGHT,
	output logic             COPY_STB,
	output logic [15:0]      COPY_TABLE,
	output logic             COPY_NUMERAL,
	output logic [15:0]      DISP_VALUE
);
	host_link_pkg::state_t state_reg;
	logic [1:0]  idx_reg;
	logic        busy_reg;
	logic        acc_start_reg;
	logic        acc_we_reg;
	logic [15:0] acc_addr_reg;
	logic [15:0] acc_wdata_reg;
	logic        acc_done;
	logic [15:0] acc_rdata;
	logic [15:0] ctrl_base_reg;
	logic [15:0] note_base_reg;
	logic [15:0] disp_addr_reg;
	logic        run_reg;
	logic [15:0] prev_sw_reg;
	logic [15:0] copy_tbl_reg;
	logic [15:0] prev_copy_tbl_reg;
	logic [15:0] prev_copy_type_reg;
	logic [15:0] changed_tbl_reg;
	logic        scr_stb_reg;
	logic        num_stb_reg;
	logic        dirty_reg;
	logic [15:0] sent_reg;
	logic [3:0]  ecnt_reg;
	logic        edrop_reg;
	logic        elast_reg;
	logic        enum_reg;
	logic [15:0] etbl_reg;
	logic [15:0] eaddr_reg;
	logic [15:0] edata_reg;
	logic [15:0] status_word;
	logic        done_sw;
	logic        done_type;
	logic        done_bits;
	logic        ev_screen;
	logic        ev_copy;
	logic        ev_light;
	logic        edit_fin;
	logic        ev_num;
	logic        note_done;
	logic        wb_hit;

	function automatic logic bcd_ok(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (v[i*4 +: 4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		for (int b = 0; b < 2; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	link_port u_link (
		.CLK        (CLK),
		.SRST       (SRST),
		.start      (acc_start_reg),
		.we         (acc_we_reg),
		.addr       (acc_addr_reg),
		.wdata      (acc_wdata_reg),
		.done       (acc_done),
		.rdata      (acc_rdata),
		.link_req   (LINK_REQ),
		.link_we    (LINK_WE),
		.link_addr  (LINK_ADDR),
		.link_wdata (LINK_WDATA),
		.link_ack   (LINK_ACK),
		.link_rdata (LINK_RDATA)
	);

	// decoded events of the current cycle
	assign done_sw   = acc_done && state_reg == host_link_pkg::S_CTRL && idx_reg == host_link_pkg::CW_SCREEN;
	assign done_type = acc_done && state_reg == host_link_pkg::S_CTRL && idx_reg == host_link_pkg::CW_COPY_TYPE;
	assign done_bits = acc_done && state_reg == host_link_pkg::S_CTRL && idx_reg == host_link_pkg::CW_BITS;
	// zero only re-arms the compare; it never selects a screen
	assign ev_screen = done_sw && acc_rdata != prev_sw_reg && acc_rdata != host_link_pkg::SCREEN_NONE
		&& bcd_ok(acc_rdata);
	assign ev_copy = done_type && {copy_tbl_reg, acc_rdata} != {prev_copy_tbl_reg, prev_copy_type_reg}
		&& copy_tbl_reg != 16'h0000 && acc_rdata <= host_link_pkg::COPY_NUMERAL;
	assign ev_light = done_bits && acc_rdata[host_link_pkg::BIT_BACKLIGHT] != BACKLIGHT;
	assign edit_fin = state_reg == host_link_pkg::S_EWR && elast_reg && (edrop_reg || acc_done);
	assign ev_num = edit_fin && enum_reg;
	assign note_done = acc_done && state_reg == host_link_pkg::S_NOTE && idx_reg == host_link_pkg::NW_STATUS;

	always_comb begin
		status_word = 16'h0000;
		status_word[host_link_pkg::ST_RUN] = run_reg;
		status_word[host_link_pkg::ST_BACKLIGHT] = BACKLIGHT;
		status_word[host_link_pkg::ST_SCREEN_STB] = scr_stb_reg;
		status_word[host_link_pkg::ST_NUM_STB] = num_stb_reg;
	end

	// sequencer: notify first, then edits, then the control poll
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_reg     <= host_link_pkg::S_IDLE;
			idx_reg       <= 2'h0;
			busy_reg      <= 1'b0;
			acc_start_reg <= 1'b0;
			acc_we_reg    <= 1'b0;
			acc_addr_reg  <= host_link_pkg::RST_BASE;
			acc_wdata_reg <= host_link_pkg::RST_WORD;
			sent_reg      <= host_link_pkg::RST_WORD;
			EDIT_READY    <= 1'b0;
		end else begin
			acc_start_reg <= 1'b0;
			unique case (state_reg)
				host_link_pkg::S_IDLE: begin
					idx_reg <= 2'h0;
					if (run_reg && dirty_reg) begin
						state_reg <= host_link_pkg::S_NOTE;
					end else if (run_reg && EDIT_VALID) begin
						EDIT_READY <= 1'b1;
						state_reg  <= host_link_pkg::S_EGET;
					end else if (run_reg) begin
						state_reg <= host_link_pkg::S_CTRL;
					end
				end
				host_link_pkg::S_CTRL: begin
					if (!busy_reg) begin
						busy_reg      <= 1'b1;
						acc_start_reg <= 1'b1;
						acc_we_reg    <= 1'b0;
						acc_addr_reg  <= ctrl_base_reg + {14'h0000, idx_reg};
					end else if (acc_done) begin
						busy_reg <= 1'b0;
						idx_reg  <= idx_reg + 2'h1;
						if (idx_reg == host_link_pkg::CW_BITS) begin
							state_reg <= host_link_pkg::S_DISP;
						end
					end
				end
				host_link_pkg::S_DISP: begin
					if (!busy_reg) begin
						busy_reg      <= 1'b1;
						acc_start_reg <= 1'b1;
						acc_we_reg    <= 1'b0;
						acc_addr_reg  <= disp_addr_reg;
					end else if (acc_done) begin
						busy_reg  <= 1'b0;
						state_reg <= host_link_pkg::S_IDLE;
					end
				end
				host_link_pkg::S_EGET: begin
					if (EDIT_VALID) begin
						EDIT_READY <= 1'b0;
						state_reg  <= host_link_pkg::S_EWR;
					end
				end
				host_link_pkg::S_EWR: begin
					if (edrop_reg) begin
						state_reg <= host_link_pkg::S_IDLE;
					end else if (!busy_reg) begin
						busy_reg      <= 1'b1;
						acc_start_reg <= 1'b1;
						acc_we_reg    <= 1'b1;
						acc_addr_reg  <= eaddr_reg;
						acc_wdata_reg <= edata_reg;
					end else if (acc_done) begin
						busy_reg  <= 1'b0;
						state_reg <= host_link_pkg::S_IDLE;
					end
				end
				host_link_pkg::S_NOTE: begin
					if (!busy_reg) begin
						busy_reg      <= 1'b1;
						acc_start_reg <= 1'b1;
						acc_we_reg    <= 1'b1;
						acc_addr_reg  <= note_base_reg + {14'h0000, idx_reg};
						unique case (idx_reg)
							host_link_pkg::NW_SCREEN: acc_wdata_reg <= SCREEN;
							host_link_pkg::NW_TABLE:  acc_wdata_reg <= changed_tbl_reg;
							default: begin
								acc_wdata_reg <= status_word;
								sent_reg      <= status_word;
							end
						endcase
					end else if (acc_done) begin
						busy_reg <= 1'b0;
						idx_reg  <= idx_reg + 2'h1;
						if (idx_reg == host_link_pkg::NW_STATUS) begin
							state_reg <= host_link_pkg::S_IDLE;
						end
					end
				end
			endcase
		end
	end

	// edit words; words past the allocation length are dropped
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ecnt_reg  <= 4'h0;
			edrop_reg <= 1'b0;
			elast_reg <= 1'b0;
			enum_reg  <= 1'b0;
			etbl_reg  <= host_link_pkg::RST_WORD;
			eaddr_reg <= host_link_pkg::RST_WORD;
			edata_reg <= host_link_pkg::RST_WORD;
		end else if (state_reg == host_link_pkg::S_EGET && EDIT_VALID) begin
			edrop_reg <= ecnt_reg >= (EDIT_NUMERAL ? host_link_pkg::NUM_MAX_WORDS
				: host_link_pkg::STR_MAX_WORDS);
			ecnt_reg  <= EDIT_LAST ? 4'h0 : (ecnt_reg == 4'hf ? ecnt_reg : ecnt_reg + 4'h1);
			elast_reg <= EDIT_LAST;
			enum_reg  <= EDIT_NUMERAL;
			etbl_reg  <= EDIT_TABLE;
			eaddr_reg <= EDIT_ADDR;
			edata_reg <= EDIT_DATA;
		end
	end

	// control area actions
	always_ff @(posedge CLK) begin
		if (SRST) begin
			prev_sw_reg        <= host_link_pkg::RST_WORD;
			SCREEN             <= host_link_pkg::SCREEN_NONE;
			copy_tbl_reg       <= host_link_pkg::RST_WORD;
			prev_copy_tbl_reg  <= host_link_pkg::RST_WORD;
			prev_copy_type_reg <= host_link_pkg::RST_WORD;
			COPY_STB           <= 1'b0;
			COPY_TABLE         <= host_link_pkg::RST_WORD;
			COPY_NUMERAL       <= 1'b0;
			BACKLIGHT          <= 1'b0;
			DISP_VALUE         <= host_link_pkg::RST_WORD;
			changed_tbl_reg    <= host_link_pkg::RST_WORD;
		end else begin
			COPY_STB <= ev_copy;
			if (done_sw) begin
				prev_sw_reg <= acc_rdata;
			end
			if (ev_screen) begin
				SCREEN <= acc_rdata;
			end
			if (acc_done && state_reg == host_link_pkg::S_CTRL && idx_reg == host_link_pkg::CW_COPY_TBL) begin
				copy_tbl_reg <= acc_rdata;
			end
			if (done_type) begin
				prev_copy_tbl_reg  <= copy_tbl_reg;
				prev_copy_type_reg <= acc_rdata;
			end
			if (ev_copy) begin
				COPY_TABLE   <= copy_tbl_reg;
				COPY_NUMERAL <= acc_rdata[0];
			end
			if (done_bits) begin
				BACKLIGHT <= acc_rdata[host_link_pkg::BIT_BACKLIGHT];
			end
			if (acc_done && state_reg == host_link_pkg::S_DISP) begin
				DISP_VALUE <= acc_rdata;
			end
			if (ev_num) begin
				changed_tbl_reg <= etbl_reg;
			end
		end
	end

	// strobes: a new event wins over the clear after delivery
	always_ff @(posedge CLK) begin
		if (SRST) begin
			scr_stb_reg <= 1'b0;
			num_stb_reg <= 1'b0;
			dirty_reg   <= host_link_pkg::RST_DIRTY;
		end else begin
			if (ev_screen) begin
				scr_stb_reg <= 1'b1;
			end else if (note_done && sent_reg[host_link_pkg::ST_SCREEN_STB]) begin
				scr_stb_reg <= 1'b0;
			end
			if (ev_num) begin
				num_stb_reg <= 1'b1;
			end else if (note_done && sent_reg[host_link_pkg::ST_NUM_STB]) begin
				num_stb_reg <= 1'b0;
			end
			// a delivered strobe needs one more write to clear it
			if (ev_screen || ev_num || ev_light) begin
				dirty_reg <= 1'b1;
			end else if (note_done) begin
				dirty_reg <= sent_reg[host_link_pkg::ST_SCREEN_STB] || sent_reg[host_link_pkg::ST_NUM_STB];
			end
		end
	end

	// register slave, one wait state, unmapped reads give zero
	assign wb_hit = CYC_I && STB_I && !ACK_O;
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ACK_O         <= 1'b0;
			DAT_O         <= 32'h00000000;
			ctrl_base_reg <= host_link_pkg::RST_BASE;
			note_base_reg <= host_link_pkg::RST_BASE;
			disp_addr_reg <= host_link_pkg::RST_BASE;
			run_reg       <= 1'b0;
		end else begin
			ACK_O <= wb_hit;
			DAT_O <= 32'h00000000;
			if (wb_hit && WE_I) begin
				unique case (ADR_I)
					host_link_pkg::OFS_CTRL_BASE:   ctrl_base_reg <= merge(ctrl_base_reg, DAT_I, SEL_I);
					host_link_pkg::OFS_NOTIFY_BASE: note_base_reg <= merge(note_base_reg, DAT_I, SEL_I);
					host_link_pkg::OFS_DISP_ADDR:   disp_addr_reg <= merge(disp_addr_reg, DAT_I, SEL_I);
					host_link_pkg::OFS_ENABLE: begin
						if (SEL_I[0]) begin
							run_reg <= DAT_I[host_link_pkg::EN_RUN];
						end
					end
					default: ;
				endcase
			end else if (wb_hit) begin
				unique case (ADR_I)
					host_link_pkg::OFS_CTRL_BASE:   DAT_O <= {16'h0000, ctrl_base_reg};
					host_link_pkg::OFS_NOTIFY_BASE: DAT_O <= {16'h0000, note_base_reg};
					host_link_pkg::OFS_DISP_ADDR:   DAT_O <= {16'h0000, disp_addr_reg};
					host_link_pkg::OFS_ENABLE:      DAT_O <= {31'h00000000, run_reg};
					host_link_pkg::OFS_STATUS:      DAT_O <= {11'h000, dirty_reg, status_word[3:0], SCREEN};
					host_link_pkg::OFS_DISP_VAL:    DAT_O <= {16'h0000, DISP_VALUE};
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	ctrl_addr_a: assert property (acc_start_reg && state_reg == host_link_pkg::S_CTRL
		|-> acc_addr_reg == ctrl_base_reg + {14'h0000, idx_reg} && !acc_we_reg)
		else $error("control read outside the area");
	note_addr_a: assert property (acc_start_reg && state_reg == host_link_pkg::S_NOTE
		|-> acc_addr_reg == note_base_reg + {14'h0000, idx_reg} && idx_reg <= host_link_pkg::NW_STATUS)
		else $error("notify write outside the area");
	screen_take_a: assert property (ev_screen |=> SCREEN == $past(acc_rdata) && scr_stb_reg)
		else $error("screen change not taken");
	same_value_a: assert property (done_sw && acc_rdata == prev_sw_reg |=> $stable(SCREEN))
		else $error("screen switched without a change");
	copy_pulse_a: assert property (ev_copy |=> COPY_STB && COPY_NUMERAL == $past(acc_rdata[0]) ##1 !COPY_STB)
		else $error("copy request not issued once");
	light_follow_a: assert property (done_bits |=> BACKLIGHT == $past(acc_rdata[host_link_pkg::BIT_BACKLIGHT]))
		else $error("backlight does not follow control bits");
	strobe_hold_a: assert property ($fell(scr_stb_reg) |-> $past(note_done) && $past(sent_reg[2]))
		else $error("screen strobe cleared before delivery");
	strobe_clear_a: assert property (note_done && sent_reg[host_link_pkg::ST_NUM_STB] && !ev_num
		|=> !num_stb_reg)
		else $error("numeral strobe did not clear");
	string_quiet_a: assert property (edit_fin && !enum_reg |=> $stable(changed_tbl_reg) && !$rose(num_stb_reg))
		else $error("string edit raised numeral notification");
	edit_limit_a: assert property (acc_start_reg && state_reg == host_link_pkg::S_EWR |-> !edrop_reg)
		else $error("edit wrote past its allocation");
endmodule // host_link_status_exchange
`default_nettype wire

// ===== host_memory_model.sv
// host controller memory model answering word accesses on the link
`timescale 1ns/10ps
`default_nettype none
module host_memory_model (
	input  wire logic        CLK,
	input  wire logic        slow,
	input  wire logic        LINK_REQ,
	input  wire logic        LINK_WE,
	input  wire logic [15:0] LINK_ADDR,
	input  wire logic [15:0] LINK_WDATA,
	output logic             LINK_ACK,
	output logic [15:0]      LINK_RDATA
);
	// areas are placed apart and in range by the bench
	logic [15:0] mem [65536];
	logic [15:0] last_reg;
	int          wait_reg;
	initial begin
		LINK_ACK = 1'b0;
		LINK_RDATA = 16'h0000;
		last_reg = 16'h0000;
		wait_reg = 0;
	end
	// read data is only valid with ack; afterwards the bus shows junk
	always @(posedge CLK) begin
		LINK_ACK <= 1'b0;
		LINK_RDATA <= ~last_reg;
		if (LINK_REQ && !LINK_ACK) begin
			if (wait_reg == 0) begin
				LINK_ACK <= 1'b1;
				wait_reg <= slow ? int'($urandom_range(5)) : 0;
				if (LINK_WE) begin
					mem[LINK_ADDR] <= LINK_WDATA;
				end else begin
					LINK_RDATA <= mem[LINK_ADDR];
					last_reg <= mem[LINK_ADDR];
				end
			end else begin
				wait_reg <= wait_reg - 1;
			end
		end
	end
endmodule // host_memory_model
`default_nettype wire

// ===== host_link_status_exchange_tb.sv
// self-checking bench for the host link status exchange block
`timescale 1ns/10ps
`default_nettype none
module host_link_status_exchange_tb;
	localparam logic [15:0] CB = 16'h0100;
	localparam logic [15:0] NB = 16'h0110;
	localparam logic [15:0] DA = 16'h0200;
	logic        CLK, SRST, CYC_I, STB_I, WE_I, ACK_O, LINK_REQ, LINK_WE, LINK_ACK, slow;
	logic        EDIT_VALID, EDIT_READY, EDIT_LAST, EDIT_NUMERAL, BACKLIGHT, COPY_STB, COPY_NUMERAL;
	logic [7:0]  ADR_I;
	logic [3:0]  SEL_I;
	logic [31:0] DAT_I, DAT_O, q;
	logic [15:0] LINK_ADDR, LINK_WDATA, LINK_RDATA, EDIT_ADDR, EDIT_DATA, EDIT_TABLE;
	logic [15:0] SCREEN, COPY_TABLE, DISP_VALUE, v, cp_tbl;
	logic        scr_stb, num_stb, cp_num;
	int          err_count, compares, cycles, polls, copies, i;
	host_link_status_exchange u_dut (.CLK(CLK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
		.ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .LINK_REQ(LINK_REQ),
		.LINK_WE(LINK_WE), .LINK_ADDR(LINK_ADDR), .LINK_WDATA(LINK_WDATA), .LINK_ACK(LINK_ACK),
		.LINK_RDATA(LINK_RDATA), .EDIT_VALID(EDIT_VALID), .EDIT_READY(EDIT_READY), .EDIT_ADDR(EDIT_ADDR),
		.EDIT_DATA(EDIT_DATA), .EDIT_LAST(EDIT_LAST), .EDIT_NUMERAL(EDIT_NUMERAL), .EDIT_TABLE(EDIT_TABLE),
		.SCREEN(SCREEN), .BACKLIGHT(BACKLIGHT), .COPY_STB(COPY_STB), .COPY_TABLE(COPY_TABLE),
		.COPY_NUMERAL(COPY_NUMERAL), .DISP_VALUE(DISP_VALUE));
	host_memory_model u_host (.CLK(CLK), .slow(slow), .LINK_REQ(LINK_REQ), .LINK_WE(LINK_WE),
		.LINK_ADDR(LINK_ADDR), .LINK_WDATA(LINK_WDATA), .LINK_ACK(LINK_ACK), .LINK_RDATA(LINK_RDATA));
	task automatic print_verdict;
		$display("Counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic single cycle; the answer is awaited, never assumed
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= a;
		DAT_I <= d;
		SEL_I <= 4'h3;
		do @(posedge CLK); while (ACK_O !== 1'b1);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I <= 1'b0;
		@(posedge CLK);
	endtask
	// waits on acknowledged reads of the control area's first word, so every wait follows the design's pace
	task automatic poll_wait(input int k);
		int t;
		t = polls + k;
		while (polls < t) @(posedge CLK);
	endtask
	task automatic edit_word(input logic [15:0] a, d, input logic l, num, input logic [15:0] tbl);
		EDIT_VALID <= 1'b1;
		EDIT_ADDR <= a;
		EDIT_DATA <= d;
		EDIT_LAST <= l;
		EDIT_NUMERAL <= num;
		EDIT_TABLE <= tbl;
		do @(posedge CLK); while (EDIT_READY !== 1'b1);
		EDIT_VALID <= 1'b0;
		@(posedge CLK);
	endtask
	// reference model: words past the table limit must leave host memory untouched
	task automatic run_edit(input logic [15:0] a, input int n, input logic num, input logic [15:0] tbl);
		logic [15:0] dq[$];
		int          k;
		for (k = 0; k < n; k++) begin
			u_host.mem[a+16'(k)] = 16'h5a5a;
			dq.push_back(16'($urandom));
		end
		for (k = 0; k < n; k++) edit_word(a + 16'(k), dq[k], k == n - 1, num, tbl);
		poll_wait(3);
		for (k = 0; k < n; k++) chk(u_host.mem[a+16'(k)], (k < (num ? 2 : 10)) ? dq[k] : 16'h5a5a);
	endtask
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (LINK_REQ && LINK_ACK && !LINK_WE && LINK_ADDR == CB) polls <= polls + 1;
		if (LINK_REQ && LINK_ACK && LINK_WE && LINK_ADDR == NB + 16'h0002) begin
			scr_stb <= scr_stb | LINK_WDATA[2];
			num_stb <= num_stb | LINK_WDATA[3];
		end
		if (COPY_STB) begin
			copies <= copies + 1;
			cp_tbl <= COPY_TABLE;
			cp_num <= COPY_NUMERAL;
		end
		if (cycles == 40000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		{SRST, CYC_I, STB_I, WE_I, ADR_I, DAT_I, SEL_I, slow} = {1'b1, 48'h0};
		{EDIT_VALID, EDIT_ADDR, EDIT_DATA, EDIT_LAST, EDIT_NUMERAL, EDIT_TABLE} = 51'h0;
		{err_count, compares, cycles, polls, copies, scr_stb, num_stb} = 0;
		q = $urandom(32'h7323834c);
		u_host.mem[CB] = 16'h0002;
		u_host.mem[CB+1] = 16'h0005;
		u_host.mem[CB+2] = 16'h0001;
		u_host.mem[CB+3] = 16'h0001;
		for (i = 0; i < 3; i++) u_host.mem[NB+16'(i)] = 16'hffff;
		v = 16'($urandom);
		u_host.mem[DA] = v;
		repeat (3) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		wb(1'b1, 8'h00, {16'h0, CB});
		wb(1'b1, 8'h04, {16'h0, NB});
		wb(1'b1, 8'h08, {16'h0, DA});
		wb(1'b1, 8'h18, 32'h1234);
		wb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk(q, {16'h0, NB});
		wb(1'b1, 8'h0c, 32'h1);
		poll_wait(3);
		chk(SCREEN, 16'h0002);
		chk(BACKLIGHT, 1'b1);
		chk(DISP_VALUE, v);
		chk({cp_tbl, 15'h0, cp_num}, 32'h00050001);
		chk(u_host.mem[NB], 16'h0002);
		chk(scr_stb, 1'b1);
		chk(u_host.mem[NB+2], 16'h0003);
		wb(1'b0, 8'h10, 32'h0);
		chk(q & 32'h0003ffff, 32'h00030002);
		wb(1'b1, 8'h14, 32'h0);
		wb(1'b0, 8'h14, 32'h0);
		chk(q, {16'h0, v});
		$display("test startup done");
		slow <= 1'b1;
		scr_stb = 1'b0;
		u_host.mem[CB] = 16'h0003;
		poll_wait(3);
		chk(SCREEN, 16'h0003);
		chk(u_host.mem[NB], 16'h0003);
		chk(scr_stb, 1'b1);
		chk(u_host.mem[NB+2] & 16'h000c, 16'h0);
		scr_stb = 1'b0;
		poll_wait(2);
		chk(scr_stb, 1'b0);
		u_host.mem[CB] = 16'h0000;
		poll_wait(2);
		u_host.mem[CB] = 16'h00a1;
		poll_wait(2);
		chk(SCREEN, 16'h0003);
		// reselect: the word moves away from the current number, so the same screen switches again
		scr_stb = 1'b0;
		u_host.mem[CB] = 16'h0003;
		poll_wait(3);
		chk({SCREEN, 15'h0, scr_stb}, 32'h00030001);
		$display("test screen done");
		u_host.mem[CB+3] = 16'h0000;
		u_host.mem[CB+1] = 16'h0006;
		u_host.mem[CB+2] = 16'h0000;
		v = 16'($urandom);
		u_host.mem[DA] = v;
		poll_wait(3);
		chk(BACKLIGHT, 1'b0);
		chk({cp_tbl, 15'h0, cp_num}, 32'h00060000);
		chk(DISP_VALUE, v);
		chk(u_host.mem[NB+2], 16'h0001);
		i = copies;
		u_host.mem[CB+1] = 16'h0007;
		u_host.mem[CB+2] = 16'h0002;
		poll_wait(3);
		chk(copies, i);
		$display("test control done");
		num_stb = 1'b0;
		run_edit(16'h0300, 3, 1'b1, 16'h0007);
		chk(u_host.mem[NB+1], 16'h0007);
		chk(num_stb, 1'b1);
		chk(u_host.mem[NB+2] & 16'h0008, 16'h0);
		num_stb = 1'b0;
		run_edit(16'h0400, 11, 1'b0, 16'h0009);
		chk(u_host.mem[NB+1], 16'h0007);
		chk(num_stb, 1'b0);
		$display("test edits done");
		print_verdict();
	end
endmodule // host_link_status_exchange_tb
`default_nettype wire
